// file: rtl/isc_pkg.sv
/*
	Shared constants and types for the instrument status condition register bank.
	Assumes one clock domain and the command port defined by isc_cmd_s.
*/
package isc_pkg;

	// ==========================================================
	// Register widths
	localparam int unsigned COND_WIDTH = 16;
	localparam int unsigned SB_WIDTH   = 8;
	localparam int unsigned NUM_GROUPS = 2;
	localparam int unsigned GRP_OPER   = 0;
	localparam int unsigned GRP_QUES   = 1;

	// ==========================================================
	// Normal-activity bit positions
	localparam int unsigned OPER_WAIT_TRIG_BIT  = 5;
	localparam int unsigned OPER_TRANS_ARM_BIT  = 6;
	localparam int unsigned OPER_CONST_VOLT_BIT = 8;
	localparam int unsigned OPER_TRANS_DONE_BIT = 9;
	localparam int unsigned OPER_CONST_CURR_BIT = 10;
	localparam int unsigned OPER_SAMPLE_BIT     = 11;
	localparam int unsigned OPER_LIST_DONE_BIT  = 12;
	localparam int unsigned OPER_LIST_RUN_BIT   = 14;

	// ==========================================================
	// Signal-quality bit positions
	localparam int unsigned QUES_VOLT_MODE_BIT = 0;
	localparam int unsigned QUES_CURR_MODE_BIT = 1;
	localparam int unsigned QUES_THERMAL_BIT   = 3;
	localparam int unsigned QUES_SLAVE_BIT     = 6;
	localparam int unsigned QUES_VOLT_PROT_BIT = 12;
	localparam int unsigned QUES_CURR_PROT_BIT = 13;
	localparam int unsigned QUES_SINKING_BIT   = 14;

	// ==========================================================
	// Readable condition masks; everything else reads zero
	localparam logic [COND_WIDTH-1:0] OPER_COND_MASK = 16'h4D60;
	localparam logic [COND_WIDTH-1:0] QUES_COND_MASK = 16'h704B;
	localparam logic [COND_WIDTH-1:0] COND_RESET     = 16'h0000;
	localparam logic [COND_WIDTH-1:0] ENABLE_RESET   = 16'h0000;

	// ==========================================================
	// Status byte layout
	localparam int unsigned SB_ERR_QUEUE_BIT = 2;
	localparam int unsigned SB_QUES_SUM_BIT  = 3;
	localparam int unsigned SB_MSG_AVAIL_BIT = 4;
	localparam int unsigned SB_STD_EVT_BIT   = 5;
	localparam int unsigned SB_SRQ_BIT       = 6;
	localparam int unsigned SB_OPER_SUM_BIT  = 7;
	localparam logic [SB_WIDTH-1:0] SB_RESET = 8'h00;

	// ==========================================================
	// Command port
	typedef enum logic [3:0]
	{
		ISC_SEL_OPER_COND   = 4'h0,
		ISC_SEL_OPER_EVENT  = 4'h1,
		ISC_SEL_OPER_ENABLE = 4'h2,
		ISC_SEL_QUES_COND   = 4'h3,
		ISC_SEL_QUES_EVENT  = 4'h4,
		ISC_SEL_QUES_ENABLE = 4'h5,
		ISC_SEL_STATUS_BYTE = 4'h6,
		ISC_SEL_SRQ_ENABLE  = 4'h7
	} isc_sel_e;

	typedef struct packed
	{
		logic                  valid;
		logic                  write;
		isc_sel_e              sel;
		logic [COND_WIDTH-1:0] wdata;
	} isc_cmd_s;

	typedef struct packed
	{
		logic                  valid;
		logic [COND_WIDTH-1:0] rdata;
	} isc_rsp_s;

	// Raw device status levels, all from outside the clock domain
	typedef struct packed
	{
		logic trigEnabled;
		logic trigSourceExt;
		logic trigInputN;
		logic transientArmed;
		logic regulationCv;
		logic regulationCc;
		logic transientDone;
		logic sampleComplete;
		logic listDone;
		logic listRunning;
		logic thermalFault;
		logic slaveFault;
		logic voltProtFault;
		logic currProtFault;
		logic extRefEnabled;
		logic sinking;
		logic errQueueNotEmpty;
		logic msgAvailable;
		logic stdEventSummary;
	} isc_pins_s;

	localparam int unsigned PIN_WIDTH = $bits(isc_pins_s);

endpackage

// file: rtl/isc_regs.sv
/*
	Status condition register bank: normal-activity and signal-quality
	condition registers with event latching, enables, status byte and service request.
	Assumes raw status levels arrive asynchronously and commands come from the
	instrument command parser on ref_clk, one per cycle at most.
*/
`timescale 1ns/100ps

module isc_regs
(
	input  wire logic               ref_clk,
	input  wire logic               resetn,
	input  wire isc_pkg::isc_pins_s pins,
	input  wire isc_pkg::isc_cmd_s  cmd,
	output isc_pkg::isc_rsp_s       rsp_reg,
	output logic                    srq_reg
);
	import isc_pkg::*;

	// ==========================================================
	// Reset release
	logic rstMeta;
	logic rstN;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rstMeta <= 1'b0;
			rstN    <= 1'b0;
		end
		else
		begin
			rstMeta <= 1'b1;
			rstN    <= rstMeta;
		end
	end

	// ==========================================================
	// Pin synchronisers
	logic [PIN_WIDTH-1:0] pinMeta;
	logic [PIN_WIDTH-1:0] pinSyncVec;
	isc_pins_s            pinSync;
	isc_pins_s            pinPrev;

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			pinMeta    <= '0;
			pinSyncVec <= '0;
		end
		else
		begin
			pinMeta    <= pins;
			pinSyncVec <= pinMeta;
		end
	end

	assign pinSync = isc_pins_s'(pinSyncVec);

	// Previous synced value, only for completion edge detection
	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
			pinPrev <= '0;
		else
			pinPrev <= pinSync;
	end

	// ==========================================================
	// Awaiting-trigger flag
	logic awaiting_trigger_flag_reg;
	logic awaiting_trigger_flag_next;

	// Externally sourced trigger held low keeps the flag up until the pin returns high
	always_comb
	begin
		awaiting_trigger_flag_next = pinSync.trigEnabled | (pinSync.trigSourceExt & ~pinSync.trigInputN);
	end

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
			awaiting_trigger_flag_reg <= 1'b0;
		else
			awaiting_trigger_flag_reg <= awaiting_trigger_flag_next;
	end

	// ==========================================================
	// Condition assembly
	logic [COND_WIDTH-1:0] operCond;
	logic [COND_WIDTH-1:0] operPulse;
	logic [COND_WIDTH-1:0] quesCond;
	logic                  anyProt;

	always_comb
	begin
		operCond                      = '0;
		operCond[OPER_WAIT_TRIG_BIT]  = awaiting_trigger_flag_reg;
		operCond[OPER_TRANS_ARM_BIT]  = pinSync.transientArmed;
		operCond[OPER_CONST_VOLT_BIT] = pinSync.regulationCv;
		operCond[OPER_CONST_CURR_BIT] = pinSync.regulationCc;
		operCond[OPER_SAMPLE_BIT]     = pinSync.sampleComplete;
		operCond[OPER_LIST_RUN_BIT]   = pinSync.listRunning;
		operCond                      = operCond & OPER_COND_MASK;
	end

	// Completion events exist only as one-cycle pulses, so no condition bit holds them
	always_comb
	begin
		operPulse                      = '0;
		operPulse[OPER_TRANS_DONE_BIT] = pinSync.transientDone & ~pinPrev.transientDone;
		operPulse[OPER_LIST_DONE_BIT]  = pinSync.listDone & ~pinPrev.listDone;
	end

	assign anyProt = pinSync.voltProtFault | pinSync.currProtFault;

	always_comb
	begin
		quesCond                     = '0;
		quesCond[QUES_VOLT_MODE_BIT] = pinSync.regulationCc;
		quesCond[QUES_CURR_MODE_BIT] = pinSync.regulationCv;
		quesCond[QUES_THERMAL_BIT]   = pinSync.thermalFault;
		quesCond[QUES_SLAVE_BIT]     = pinSync.slaveFault;
		quesCond[QUES_VOLT_PROT_BIT] = pinSync.voltProtFault | (pinSync.extRefEnabled & anyProt);
		quesCond[QUES_CURR_PROT_BIT] = pinSync.currProtFault | (pinSync.extRefEnabled & anyProt);
		quesCond[QUES_SINKING_BIT]   = pinSync.sinking;
		quesCond                     = quesCond & QUES_COND_MASK;
	end

	// ==========================================================
	// Command decoding
	function automatic logic selIs(input isc_cmd_s c, input isc_sel_e s, input logic wr);
		selIs = c.valid && (c.write == wr) && (c.sel == s);
	endfunction

	logic [COND_WIDTH-1:0] grpCondIn    [NUM_GROUPS];
	logic [COND_WIDTH-1:0] grpPulseIn   [NUM_GROUPS];
	logic                  grpReadEvent [NUM_GROUPS];
	logic                  grpWriteEn   [NUM_GROUPS];
	logic [COND_WIDTH-1:0] grpCond      [NUM_GROUPS];
	logic [COND_WIDTH-1:0] grpEvent     [NUM_GROUPS];
	logic [COND_WIDTH-1:0] grpEnable    [NUM_GROUPS];
	logic                  grpSummary   [NUM_GROUPS];

	assign grpCondIn[GRP_OPER]    = operCond;
	assign grpCondIn[GRP_QUES]    = quesCond;
	assign grpPulseIn[GRP_OPER]   = operPulse;
	assign grpPulseIn[GRP_QUES]   = '0;
	assign grpReadEvent[GRP_OPER] = selIs(cmd, ISC_SEL_OPER_EVENT, 1'b0);
	assign grpReadEvent[GRP_QUES] = selIs(cmd, ISC_SEL_QUES_EVENT, 1'b0);
	assign grpWriteEn[GRP_OPER]   = selIs(cmd, ISC_SEL_OPER_ENABLE, 1'b1);
	assign grpWriteEn[GRP_QUES]   = selIs(cmd, ISC_SEL_QUES_ENABLE, 1'b1);

	// ==========================================================
	// Register groups
	genvar g;
	generate
		for (g = 0; g < NUM_GROUPS; g++)
		begin : gGroup
			isc_status_group
			#(
				.WIDTH (COND_WIDTH)
			)
			uGroup
			(
				.clk         (ref_clk),
				.rstN        (rstN),
				.condIn      (grpCondIn[g]),
				.pulseIn     (grpPulseIn[g]),
				.readEvent   (grpReadEvent[g]),
				.writeEnable (grpWriteEn[g]),
				.wdata       (cmd.wdata),
				.cond_reg    (grpCond[g]),
				.event_reg   (grpEvent[g]),
				.enable_reg  (grpEnable[g]),
				.summary_reg (grpSummary[g])
			);
		end
	endgenerate

	// ==========================================================
	// Status byte and service request
	logic [SB_WIDTH-1:0] srqEnable_reg;
	logic [SB_WIDTH-1:0] statusByte;
	logic                srqBit;

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
			srqEnable_reg <= SB_RESET;
		else if (selIs(cmd, ISC_SEL_SRQ_ENABLE, 1'b1))
			srqEnable_reg <= cmd.wdata[SB_WIDTH-1:0];
	end

	always_comb
	begin
		statusByte                   = '0;
		statusByte[SB_ERR_QUEUE_BIT] = pinSync.errQueueNotEmpty;
		statusByte[SB_QUES_SUM_BIT]  = grpSummary[GRP_QUES];
		statusByte[SB_MSG_AVAIL_BIT] = pinSync.msgAvailable;
		statusByte[SB_STD_EVT_BIT]   = pinSync.stdEventSummary;
		statusByte[SB_OPER_SUM_BIT]  = grpSummary[GRP_OPER];
		// Bit 6 is its own result, so it is excluded from the AND-OR
		srqBit                       = |((statusByte & srqEnable_reg) & ~(SB_RESET | (8'h01 << SB_SRQ_BIT)));
		statusByte[SB_SRQ_BIT]       = srqBit;
	end

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
			srq_reg <= 1'b0;
		else
			srq_reg <= srqBit;
	end

	// ==========================================================
	// Read response, one cycle after the command; unmapped selects read zero
	isc_rsp_s rsp_next;

	always_comb
	begin
		rsp_next.valid = cmd.valid;
		rsp_next.rdata = '0;
		if (cmd.valid && !cmd.write)
		begin
			case (cmd.sel)
				ISC_SEL_OPER_COND:   rsp_next.rdata = grpCond[GRP_OPER] & OPER_COND_MASK;
				ISC_SEL_OPER_EVENT:  rsp_next.rdata = grpEvent[GRP_OPER];
				ISC_SEL_OPER_ENABLE: rsp_next.rdata = grpEnable[GRP_OPER];
				ISC_SEL_QUES_COND:   rsp_next.rdata = grpCond[GRP_QUES] & QUES_COND_MASK;
				ISC_SEL_QUES_EVENT:  rsp_next.rdata = grpEvent[GRP_QUES];
				ISC_SEL_QUES_ENABLE: rsp_next.rdata = grpEnable[GRP_QUES];
				ISC_SEL_STATUS_BYTE: rsp_next.rdata = {{(COND_WIDTH-SB_WIDTH){1'b0}}, statusByte};
				ISC_SEL_SRQ_ENABLE:  rsp_next.rdata = {{(COND_WIDTH-SB_WIDTH){1'b0}}, srqEnable_reg};
				default:             rsp_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
			rsp_reg <= '0;
		else
			rsp_reg <= rsp_next;
	end

endmodule

// file: rtl/isc_status_group.sv
/*
	One condition / event / enable register group with its summary bit.
	Assumes the condition input is already masked and synchronous to clk.
*/
`timescale 1ns/100ps

module isc_status_group
#(
	parameter int unsigned WIDTH = isc_pkg::COND_WIDTH
)
(
	input  wire logic             clk,
	input  wire logic             rstN,
	input  wire logic [WIDTH-1:0] condIn,
	input  wire logic [WIDTH-1:0] pulseIn,
	input  wire logic             readEvent,
	input  wire logic             writeEnable,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] cond_reg,
	output logic      [WIDTH-1:0] event_reg,
	output logic      [WIDTH-1:0] enable_reg,
	output logic                  summary_reg
);
	import isc_pkg::*;

	// ==========================================================
	// Parameter check
	if (WIDTH < 1 || WIDTH > COND_WIDTH)
	begin : gWidthCheck
		$error("isc_status_group: WIDTH out of range");
	end

	logic [WIDTH-1:0] rise;
	logic [WIDTH-1:0] event_next;

	// ==========================================================
	// Condition and edge capture
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			cond_reg <= COND_RESET[WIDTH-1:0];
		else
			cond_reg <= condIn;
	end

	assign rise = (condIn & ~cond_reg) | pulseIn;

	// Set wins over the read-clear so an edge in the read cycle survives
	always_comb
	begin
		event_next = event_reg;
		if (readEvent)
			event_next = '0;
		event_next = event_next | rise;
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			event_reg <= COND_RESET[WIDTH-1:0];
		else
			event_reg <= event_next;
	end

	// ==========================================================
	// Enable and summary
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			enable_reg <= ENABLE_RESET[WIDTH-1:0];
		else if (writeEnable)
			enable_reg <= wdata;
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			summary_reg <= 1'b0;
		else
			summary_reg <= |(event_next & enable_reg);
	end

endmodule

// file: test/isc_exp.svh
/*
	Expected condition words worked out from the raw status levels.
	Assumes isc_pkg is compiled first.
*/
`ifndef ISC_EXP_SVH
`define ISC_EXP_SVH
// ====================
// Expected condition words
function automatic logic [15:0] iscExpOper(isc_pkg::isc_pins_s p);
	return {1'h0, p.listRunning, 2'h0, p.sampleComplete, p.regulationCc, 1'h0, p.regulationCv, 1'h0,
		p.transientArmed, p.trigEnabled | (p.trigSourceExt & ~p.trigInputN), 5'h00};
endfunction
function automatic logic [15:0] iscExpQues(isc_pkg::isc_pins_s p);
	logic prot;
	prot = p.extRefEnabled & (p.voltProtFault | p.currProtFault);
	return {1'h0, p.sinking, p.currProtFault | prot, p.voltProtFault | prot, 5'h00, p.slaveFault, 2'h0,
		p.thermalFault, 1'h0, p.regulationCv, p.regulationCc};
endfunction
`endif

// file: test/isc_host_model.sv
/*
	Host side model: one command per call on the command port.
	Assumes commands change at the falling edge of ref_clk.
*/
`timescale 1ns/100ps

module isc_host_model
(
	input  wire logic        ref_clk,
	output isc_pkg::isc_cmd_s cmd
);
	import isc_pkg::*;

	// ====================
	// Command issue; valid stands one cycle, then one idle cycle
	initial cmd = '0;

	task automatic issue(input logic w, input isc_sel_e s, input logic [15:0] d);
		@(negedge ref_clk);
		cmd = {1'h1, w, s, d};
		@(negedge ref_clk);
		cmd.valid = 1'h0;
	endtask
endmodule

// file: test/isc_regs_sva.sv
/*
	Checker for isc_regs, bound into each isc_regs instance.
	Assumes levels read as settled after six stable cycles.
*/
`timescale 1ns/100ps
`include "isc_exp.svh"

module isc_regs_sva
(
	input wire logic               ref_clk,
	input wire logic               resetn,
	input wire isc_pkg::isc_pins_s pins,
	input wire isc_pkg::isc_cmd_s  cmd,
	input wire isc_pkg::isc_rsp_s  rsp_reg,
	input wire logic               srq_reg
);
	import isc_pkg::*;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// ====================
	// Steps
	sequence settled;
		$stable(pins) [*6];
	endsequence
	sequence rdSel(isc_sel_e s);
		cmd.valid && !cmd.write && cmd.sel == s;
	endsequence

	// ====================
	// Properties
	rsp_timing_a:
		assert property (cmd.valid |=> rsp_reg.valid)
		else $error("no response after command");
	rsp_cause_a:
		assert property (rsp_reg.valid |-> $past(cmd.valid))
		else $error("response without command");
	oper_unused_a:
		assert property (rdSel(ISC_SEL_OPER_COND) |=> (rsp_reg.rdata & ~OPER_COND_MASK) == 16'h0000)
		else $error("unused operation bit set");
	ques_unused_a:
		assert property (rdSel(ISC_SEL_QUES_COND) |=> (rsp_reg.rdata & ~QUES_COND_MASK) == 16'h0000)
		else $error("unused quality bit set");
	oper_value_a:
		assert property (settled ##0 rdSel(ISC_SEL_OPER_COND) |=> rsp_reg.rdata == iscExpOper($past(pins)))
		else $error("operation condition wrong");
	ques_value_a:
		assert property (settled ##0 rdSel(ISC_SEL_QUES_COND) |=> rsp_reg.rdata == iscExpQues($past(pins)))
		else $error("quality condition wrong");
	event_clear_a:
		assert property (settled ##0 rdSel(ISC_SEL_OPER_EVENT) ##2 rdSel(ISC_SEL_OPER_EVENT)
			|=> rsp_reg.rdata == 16'h0000)
		else $error("event not cleared by read");
	write_zero_a:
		assert property (cmd.valid && (cmd.write || cmd.sel > ISC_SEL_SRQ_ENABLE) |=> rsp_reg.rdata == 16'h0000)
		else $error("write or unmapped read data");
endmodule

bind isc_regs isc_regs_sva u_sva (.ref_clk(ref_clk), .resetn(resetn), .pins(pins), .cmd(cmd),
	.rsp_reg(rsp_reg), .srq_reg(srq_reg));

// file: test/tb_top.sv
/*
	Self-checking bench for isc_regs: random levels, events, enables and service request.
	Assumes the host model drives commands and the checker is bound.
*/
`timescale 1ns/100ps
`include "isc_exp.svh"

module tb_top;
	import isc_pkg::*;

	typedef struct packed {logic [15:0] val; logic [15:0] mask;} isc_note_s;
	localparam logic [15:0] NONE = 16'h0000;
	localparam logic [15:0] ALL  = 16'hFFFF;

	logic      refClk;
	logic      resetn     = 1'h0;
	isc_pins_s pins       = '0;
	isc_pins_s pv;
	isc_cmd_s  cmd;
	isc_rsp_s  rsp;
	logic      srq;
	isc_note_s noteQ[$];
	isc_note_s note;
	int        errCount   = 0;
	int        checkCount = 0;
	int        cycles     = 0;
	int        seed       = 28402;

	isc_regs uut (.ref_clk(refClk), .resetn(resetn), .pins(pins), .cmd(cmd), .rsp_reg(rsp), .srq_reg(srq));
	isc_host_model host (.ref_clk(refClk), .cmd(cmd));

	// ====================
	// Clock and timeout
	initial
	begin
		refClk = 1'h0;
		forever #12.5 refClk = ~refClk;
	end

	always @(posedge refClk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			bad("timeout");
			finishTest();
		end
	end

	// ====================
	// Tasks
	task automatic bad(input string m);
		errCount++;
		$display("BAD %0t %s", $time, m);
	endtask

	task automatic finishTest;
		$display("errors %0d checks %0d", errCount, checkCount);
		if (errCount == 0 && checkCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic acc(input logic w, input isc_sel_e s, input logic [15:0] d, input logic [15:0] v,
		input logic [15:0] m);
		noteQ.push_back('{v, m});
		host.issue(w, s, d);
	endtask

	task automatic setPins(input isc_pins_s p);
		@(negedge refClk);
		pins = p;
		repeat (6) @(negedge refClk);
	endtask

	// Fixed wait: event to summary to service request is two edges
	task automatic srqIs(input logic e);
		repeat (4) @(negedge refClk);
		checkCount++;
		if (srq !== e)
			bad("service request level");
	endtask

	// ====================
	// Response monitor; sampled mid-cycle where the response is settled
	always @(negedge refClk)
	begin
		if (rsp.valid === 1'h1)
		begin
			checkCount++;
			if (noteQ.size() == 0)
				bad("unexpected response");
			else
			begin
				note = noteQ.pop_front();
				if ((rsp.rdata & note.mask) !== (note.val & note.mask))
					bad("read data mismatch");
			end
		end
	end

	// ====================
	// Main sequence
	initial
	begin
		repeat (12) @(negedge refClk);
		resetn = 1'h1;
		repeat (4) @(negedge refClk);
		for (int i = 0; i < 24; i++)
		begin
			setPins(isc_pins_s'(PIN_WIDTH'($random(seed))));
			acc(1'h0, ISC_SEL_OPER_COND, NONE, iscExpOper(pins), ALL);
			acc(1'h0, ISC_SEL_QUES_COND, NONE, iscExpQues(pins), ALL);
			// Enables still at reset, so summaries and bit 6 must read zero here
			acc(1'h0, ISC_SEL_STATUS_BYTE, NONE,
				{10'h000, pins.stdEventSummary, pins.msgAvailable, 1'h0, pins.errQueueNotEmpty, 2'h0}, ALL);
		end
		setPins('0);
		acc(1'h0, ISC_SEL_OPER_EVENT, NONE, NONE, NONE);
		acc(1'h0, ISC_SEL_QUES_EVENT, NONE, NONE, NONE);
		pv = '0;
		pv.regulationCv = 1'h1;
		pv.transientDone = 1'h1;
		pv.listDone = 1'h1;
		setPins(pv);
		acc(1'h0, ISC_SEL_OPER_COND, NONE, 16'h0100, ALL);
		acc(1'h0, ISC_SEL_QUES_COND, NONE, 16'h0002, ALL);
		acc(1'h1, ISC_SEL_OPER_ENABLE, 16'h0001, NONE, ALL);
		acc(1'h1, ISC_SEL_SRQ_ENABLE, 16'h0080, NONE, ALL);
		srqIs(1'h0);
		acc(1'h1, ISC_SEL_OPER_ENABLE, 16'h1000, NONE, ALL);
		srqIs(1'h1);
		acc(1'h0, ISC_SEL_STATUS_BYTE, NONE, 16'h00C0, ALL);
		acc(1'h0, ISC_SEL_OPER_ENABLE, NONE, 16'h1000, ALL);
		acc(1'h0, ISC_SEL_OPER_EVENT, NONE, 16'h1300, ALL);
		acc(1'h0, ISC_SEL_OPER_EVENT, NONE, NONE, ALL);
		acc(1'h1, ISC_SEL_QUES_ENABLE, 16'h0002, NONE, ALL);
		acc(1'h1, ISC_SEL_SRQ_ENABLE, 16'h0008, NONE, ALL);
		srqIs(1'h1);
		acc(1'h0, ISC_SEL_STATUS_BYTE, NONE, 16'h0048, ALL);
		acc(1'h0, ISC_SEL_QUES_ENABLE, NONE, 16'h0002, ALL);
		acc(1'h0, ISC_SEL_SRQ_ENABLE, NONE, 16'h0008, ALL);
		acc(1'h0, ISC_SEL_QUES_EVENT, NONE, 16'h0002, ALL);
		srqIs(1'h0);
		acc(1'h0, ISC_SEL_QUES_EVENT, NONE, NONE, ALL);
		acc(1'h1, ISC_SEL_OPER_COND, ALL, NONE, ALL);
		acc(1'h0, ISC_SEL_OPER_COND, NONE, 16'h0100, ALL);
		acc(1'h0, isc_sel_e'(4'hF), NONE, NONE, ALL);
		repeat (4) @(negedge refClk);
		checkCount++;
		if (noteQ.size() != 0)
			bad("responses missing");
		finishTest();
	end
endmodule
